// File: shared/sapm_regs.svh
// constants of the serial converter frame and power-mode block
`ifndef SAPM_REGS_SVH
`define SAPM_REGS_SVH

`define SAPM_WORD_W      16
`define SAPM_RES_W       12
`define SAPM_CNT_W       5
`define SAPM_LEAD_ZEROS  4
`define SAPM_FALL_PD_MIN 5'h02
`define SAPM_FALL_KEEP   5'h0a
`define SAPM_FALL_LAST   5'h0f
`define SAPM_FALL_FRAME  5'h10
`define SAPM_NEED_12     5'h10
`define SAPM_NEED_10     5'h0e
`define SAPM_NEED_8      5'h0c
`define SAPM_PIN_RST     1'b1
`define SAPM_BUF_DEPTH   2

`endif

// File: shared/sapm_pkg.sv
// types of the serial converter frame and power-mode block
`include "sapm_regs.svh"
package sapm_pkg;
	typedef enum logic [1:0] {
		SAPM_RES12 = 2'h0,
		SAPM_RES10 = 2'h1,
		SAPM_RES8  = 2'h2
	} sapm_res_t;

	typedef enum logic [1:0] {
		SAPM_MODE_NORMAL = 2'h1,
		SAPM_MODE_DOWN   = 2'h2
	} sapm_mode_t;

	typedef enum logic [2:0] {
		SAPM_FR_IDLE  = 3'h1,
		SAPM_FR_SHIFT = 3'h2,
		SAPM_FR_HOLD  = 3'h4
	} sapm_frame_t;

	typedef logic [`SAPM_RES_W-1:0] sapm_word_t;
endpackage

// File: shared/sapm_word_if.sv
// result word stream between the buffer and the frame logic
`timescale 1ns/100ps
interface sapm_word_if;
	import sapm_pkg::*;
	logic       valid;
	logic       ready;
	sapm_word_t data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// File: src/sapm_pin_sync.sv
// two-flop synchroniser for the host pins
`timescale 1ns/100ps
`include "sapm_regs.svh"
module sapm_pin_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q   <= {W{`SAPM_PIN_RST}};
			pin_sync <= {W{`SAPM_PIN_RST}};
		end else begin
			meta_q   <= pin_in;
			pin_sync <= meta_q;
		end
	end
endmodule // sapm_pin_sync

// File: src/sapm_buf.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "sapm_regs.svh"
module sapm_buf
	import sapm_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire sapm_word_t in_data,
	input  wire logic  in_valid,
	output logic       in_ready,
	sapm_word_if.src   out
);
	sapm_word_t mem_q [`SAPM_BUF_DEPTH];
	logic       wr_q;
	logic       rd_q;
	logic [1:0] cnt_q;
	logic       push;
	logic       pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out.valid = (cnt_q != 2'h0);
	assign out.data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out.valid && out.ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_q  <= 1'b0;
			rd_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wr_q <= ~wr_q;
			end
			if (pop) begin
				rd_q <= ~rd_q;
			end
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// a stalled full buffer must keep its head word untouched
	property p_buf_full_stalls;
		@(posedge clk) disable iff (!rst_n)
		(!in_ready && !pop) |=> (cnt_q == 2'h2) && (mem_q[rd_q] == $past(mem_q[rd_q]));
	endproperty
	a_buf_full_stalls: assert property (p_buf_full_stalls)
		else $error("full buffer lost or changed a word");
endmodule // sapm_buf

// File: src/sapm_top.sv
// frame, serial output and power-mode control of the converter
`timescale 1ns/100ps
`include "sapm_regs.svh"
module sapm_top
	import sapm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       cs_n_pin,
	input  wire logic       sclk_pin,
	input  wire sapm_res_t  res_sel,
	input  wire sapm_word_t smp_data,
	input  wire logic       smp_valid,
	output logic            smp_ready,
	output logic            serial_result_out,
	output logic            serial_result_oe,
	output logic            sample_strobe,
	output logic            powered,
	output logic            frame_valid,
	output logic            conv_abort,
	output logic            conv_done
);
	logic [1:0]            pins_s;
	logic                  cs_n_s;
	logic                  sclk_s;
	logic                  cs_n_d_q;
	logic                  sclk_d_q;
	logic                  cs_fall;
	logic                  cs_rise;
	logic                  sclk_fall;
	logic                  step;
	logic                  last_fall;
	logic                  done_w;
	sapm_frame_t           frame_q;
	sapm_mode_t            mode_q;
	logic [`SAPM_CNT_W-1:0]  fall_cnt_q;
	logic [`SAPM_WORD_W-1:0] shift_q;
	sapm_res_t             res_q;

	sapm_word_if word_if ();

	// zero-padded 16-bit word for the selected resolution
	function automatic logic [`SAPM_WORD_W-1:0] fmt_word(
		input sapm_word_t r,
		input sapm_res_t  s
	);
		logic [`SAPM_WORD_W-1:0] w;
		w = '0;
		case (s)
			SAPM_RES12: w = {4'h0, r};
			SAPM_RES10: w = {4'h0, r[9:0], 2'h0};
			SAPM_RES8:  w = {4'h0, r[7:0], 4'h0};
			default:    w = '0;
		endcase
		return w;
	endfunction

	// falling edges a frame needs before the result is complete
	function automatic logic [`SAPM_CNT_W-1:0] falls_needed(input sapm_res_t s);
		logic [`SAPM_CNT_W-1:0] n;
		n = `SAPM_NEED_12;
		case (s)
			SAPM_RES12: n = `SAPM_NEED_12;
			SAPM_RES10: n = `SAPM_NEED_10;
			SAPM_RES8:  n = `SAPM_NEED_8;
			default:    n = `SAPM_NEED_12;
		endcase
		return n;
	endfunction

	sapm_pin_sync #(
		.W (2)
	) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.pin_in   ({cs_n_pin, sclk_pin}),
		.pin_sync (pins_s)
	);

	assign cs_n_s = pins_s[1];
	assign sclk_s = pins_s[0];

	// converter results queue here while no frame asks for them
	sapm_buf u_buf (
		.clk      (clk),
		.rst_n    (rst_n),
		.in_data  (smp_data),
		.in_valid (smp_valid),
		.in_ready (smp_ready),
		.out      (word_if.src)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cs_n_d_q <= `SAPM_PIN_RST;
			sclk_d_q <= `SAPM_PIN_RST;
		end else begin
			cs_n_d_q <= cs_n_s;
			sclk_d_q <= sclk_s;
		end
	end

	assign cs_fall   = cs_n_d_q && !cs_n_s;
	assign cs_rise   = !cs_n_d_q && cs_n_s;
	assign sclk_fall = sclk_d_q && !sclk_s;
	// a rise of select in the same cycle wins over the clock edge
	assign step      = (frame_q == SAPM_FR_SHIFT) && sclk_fall && !cs_rise;
	assign last_fall = step && (fall_cnt_q == `SAPM_FALL_LAST);
	assign done_w    = (fall_cnt_q >= falls_needed(res_q));

	// one word taken per frame, at the select falling edge
	assign word_if.ready = cs_fall;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_q <= SAPM_FR_IDLE;
		end else if (cs_rise) begin
			frame_q <= SAPM_FR_IDLE;
		end else if (cs_fall) begin
			frame_q <= SAPM_FR_SHIFT;
		end else if (last_fall) begin
			frame_q <= SAPM_FR_HOLD;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fall_cnt_q <= '0;
		end else if (cs_fall) begin
			fall_cnt_q <= '0;
		end else if (step) begin
			fall_cnt_q <= fall_cnt_q + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			res_q <= SAPM_RES12;
		end else if (cs_fall) begin
			res_q <= res_sel;
		end
	end

	// empty buffer gives a zero result rather than stalling the host
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift_q <= '0;
		end else if (cs_fall) begin
			shift_q <= fmt_word(word_if.valid ? word_if.data : '0, res_sel);
		end else if (step) begin
			shift_q <= {shift_q[`SAPM_WORD_W-2:0], 1'b0};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			serial_result_oe <= 1'b0;
		end else if (cs_rise) begin
			serial_result_oe <= 1'b0;
		end else if (cs_fall) begin
			serial_result_oe <= 1'b1;
		end else if (last_fall) begin
			serial_result_oe <= 1'b0;
		end
	end

	assign serial_result_out = shift_q[`SAPM_WORD_W-1];

	// device always starts in down after reset; this forces a dummy frame first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q <= SAPM_MODE_DOWN;
		end else if (cs_rise && (frame_q != SAPM_FR_IDLE)) begin
			unique case (mode_q)
				SAPM_MODE_NORMAL: begin
					// below two falls a glitch is ignored
					if (fall_cnt_q >= `SAPM_FALL_PD_MIN && fall_cnt_q < `SAPM_FALL_KEEP) begin
						mode_q <= SAPM_MODE_DOWN;
					end
				end
				SAPM_MODE_DOWN: begin
					if (fall_cnt_q >= `SAPM_FALL_KEEP) begin
						mode_q <= SAPM_MODE_NORMAL;
					end
				end
			endcase
		end else if (last_fall && mode_q == SAPM_MODE_DOWN) begin
			mode_q <= SAPM_MODE_NORMAL;
		end
	end

	assign powered = (mode_q == SAPM_MODE_NORMAL);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_valid <= 1'b0;
		end else if (cs_fall) begin
			frame_valid <= (mode_q == SAPM_MODE_NORMAL);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sample_strobe <= 1'b0;
			conv_abort    <= 1'b0;
			conv_done     <= 1'b0;
		end else begin
			sample_strobe <= cs_fall;
			conv_abort    <= cs_rise && (frame_q == SAPM_FR_SHIFT) && !done_w;
			conv_done     <= step && (fall_cnt_q + 5'h01 == falls_needed(res_q));
		end
	end

	property p_lead_zeros;
		@(posedge clk) disable iff (!rst_n)
		cs_fall |=> (shift_q[15:12] == 4'h0) && serial_result_oe;
	endproperty
	a_lead_zeros: assert property (p_lead_zeros)
		else $error("word does not open with four zeros");

	property p_trail_zeros;
		@(posedge clk) disable iff (!rst_n)
		(cs_fall && res_sel == SAPM_RES10) |=> (shift_q[1:0] == 2'h0);
	endproperty
	a_trail_zeros: assert property (p_trail_zeros)
		else $error("10-bit word lacks trailing zeros");

	property p_frame_start;
		@(posedge clk) disable iff (!rst_n)
		cs_fall |=> (frame_q == SAPM_FR_SHIFT) && (fall_cnt_q == 5'h00) && sample_strobe
			##1 !sample_strobe;
	endproperty
	a_frame_start: assert property (p_frame_start)
		else $error("select fall did not start a frame");

	property p_power_down;
		@(posedge clk) disable iff (!rst_n)
		(cs_rise && frame_q == SAPM_FR_SHIFT && mode_q == SAPM_MODE_NORMAL
			&& fall_cnt_q >= 5'h02 && fall_cnt_q < 5'h0a)
			|=> (mode_q == SAPM_MODE_DOWN) && !serial_result_oe;
	endproperty
	a_power_down: assert property (p_power_down)
		else $error("rise in power-down window missed");

	property p_glitch_keep;
		@(posedge clk) disable iff (!rst_n)
		(cs_rise && mode_q == SAPM_MODE_NORMAL && fall_cnt_q < 5'h02)
			|=> mode_q == SAPM_MODE_NORMAL;
	endproperty
	a_glitch_keep: assert property (p_glitch_keep)
		else $error("early select rise powered down");

	property p_late_abort;
		@(posedge clk) disable iff (!rst_n)
		(cs_rise && frame_q == SAPM_FR_SHIFT && mode_q == SAPM_MODE_NORMAL
			&& fall_cnt_q >= 5'h0a && !done_w)
			|=> powered && conv_abort && !serial_result_oe;
	endproperty
	a_late_abort: assert property (p_late_abort)
		else $error("late rise did not abort while powered");

	property p_stay_down;
		@(posedge clk) disable iff (!rst_n)
		(cs_rise && frame_q == SAPM_FR_SHIFT && mode_q == SAPM_MODE_DOWN
			&& fall_cnt_q < 5'h0a) |=> mode_q == SAPM_MODE_DOWN;
	endproperty
	a_stay_down: assert property (p_stay_down)
		else $error("short dummy frame woke the device");

	property p_shift_msb;
		@(posedge clk) disable iff (!rst_n)
		step |=> shift_q == {$past(shift_q[14:0]), 1'b0};
	endproperty
	a_shift_msb: assert property (p_shift_msb)
		else $error("word not shifted one bit per clock");

	property p_release_16;
		@(posedge clk) disable iff (!rst_n)
		last_fall |=> !serial_result_oe && (fall_cnt_q == 5'h10) && (frame_q == SAPM_FR_HOLD);
	endproperty
	a_release_16: assert property (p_release_16)
		else $error("output not released after sixteen falls");

	property p_dummy_invalid;
		@(posedge clk) disable iff (!rst_n)
		(cs_fall && mode_q == SAPM_MODE_DOWN) |=> !frame_valid;
	endproperty
	a_dummy_invalid: assert property (p_dummy_invalid)
		else $error("dummy frame marked valid");
endmodule // sapm_top

// File: tb/sapm_host_model.sv
// host-side model driving select and serial clock of the converter block
`timescale 1ns/100ps
module sapm_host_model #(
	parameter int HALF  = 4,
	parameter int QUIET = 6
) (
	input  wire logic clk,
	input  wire logic serial_result_out,
	input  wire logic serial_result_oe,
	output logic      cs_n_pin,
	output logic      sclk_pin
);
	logic [15:0] word_q;

	// serial clock idles high and stands still outside frames
	initial begin
		cs_n_pin = 1'b1;
		sclk_pin = 1'b1;
		word_q = 16'h0000;
	end

	task automatic frame(input int falls);
		word_q = 16'h0000;
		@(posedge clk);
		cs_n_pin <= 1'b0;
		repeat (HALF) @(posedge clk);
		for (int k = 0; k < falls; k++) begin
			@(negedge clk);
			// released line reads unknown, so a late enable never matches
			word_q = {word_q[14:0], serial_result_oe ? serial_result_out : 1'bx};
			@(posedge clk);
			sclk_pin <= 1'b0;
			repeat (HALF) @(posedge clk);
			sclk_pin <= 1'b1;
			repeat (HALF) @(posedge clk);
		end
		cs_n_pin <= 1'b1;
		repeat (QUIET) @(posedge clk);
	endtask
endmodule // sapm_host_model

// File: tb/tb_serial_adc_frame_power_mode.sv
// self-checking bench of the converter frame and power-mode block
`timescale 1ns/100ps
module tb_serial_adc_frame_power_mode;
	import sapm_pkg::*;
	typedef struct packed {
		sapm_res_t   res;
		sapm_word_t  d;
		logic [15:0] w;
	} sapm_row_t;

	logic       clk, rst_n, cs_n_pin, sclk_pin, smp_valid, smp_ready, sro, soe;
	logic       strobe, powered, fv, abort, done, fv_q;
	sapm_res_t  res_sel;
	sapm_word_t smp_data;
	int         miscompares, num_checks, cycles, n_abort, n_done, n_strobe;
	sapm_row_t  rows [4] = '{'{SAPM_RES12, 12'ha5c, 16'h0a5c},
		'{SAPM_RES10, 12'h2f3, 16'h0bcc}, '{SAPM_RES8, 12'h081, 16'h0810},
		'{SAPM_RES12, 12'hfff, 16'h0fff}};
	sapm_word_t bufw [3] = '{12'h3c1, 12'h7e2, 12'h000};

	sapm_top DUT (.clk(clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
		.res_sel(res_sel), .smp_data(smp_data), .smp_valid(smp_valid),
		.smp_ready(smp_ready), .serial_result_out(sro), .serial_result_oe(soe),
		.sample_strobe(strobe), .powered(powered), .frame_valid(fv),
		.conv_abort(abort), .conv_done(done));
	sapm_host_model HOST (.clk(clk), .serial_result_out(sro), .serial_result_oe(soe),
		.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// pulse counters; limit is nearly three times the planned run
	always @(posedge clk) begin
		cycles++;
		if (rst_n && abort === 1'b1) n_abort++;
		if (rst_n && done === 1'b1) n_done++;
		if (rst_n && strobe === 1'b1) n_strobe++;
		if (done === 1'b1) fv_q <= fv;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic push(input sapm_word_t d);
		smp_data <= d;
		smp_valid <= 1'b1;
		@(posedge clk);
		while (smp_ready !== 1'b1) @(posedge clk);
		smp_valid <= 1'b0;
		// idle edge so a following push never drives valid twice in one step
		@(posedge clk);
	endtask

	// one frame, then mode, release and pulse counts
	task automatic go(input int falls, input logic pw, input int ab, input int dn);
		int a0, d0, s0;
		a0 = n_abort;
		d0 = n_done;
		s0 = n_strobe;
		HOST.frame(falls);
		chk({14'h0, powered, soe}, {14'h0, pw, 1'b0});
		chk(16'(n_abort - a0), 16'(ab));
		chk(16'(n_done - d0), 16'(dn));
		chk(16'(n_strobe - s0), 16'h0001);
	endtask

	initial begin
		rst_n = 1'b0;
		res_sel = SAPM_RES12;
		smp_data = 12'h000;
		smp_valid = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk({13'h0, powered, soe, smp_ready}, 16'h0001);
		$display("reset test done");
		go(16, 1'b1, 0, 1);
		chk(16'(fv_q), 16'h0000);
		$display("wake test done");
		foreach (rows[i]) begin
			res_sel <= rows[i].res;
			push(rows[i].d);
			go(16, 1'b1, 0, 1);
			chk(HOST.word_q, rows[i].w);
			chk(16'(fv_q), 16'h0001);
			$display("row %0d done", i);
		end
		res_sel <= SAPM_RES8;
		push(12'h05a);
		go(12, 1'b1, 0, 1);
		chk(HOST.word_q, 16'h005a);
		$display("short frame test done");
		go(1, 1'b1, 1, 0);
		go(5, 1'b0, 1, 0);
		go(8, 1'b0, 1, 0);
		go(11, 1'b1, 1, 0);
		go(11, 1'b1, 1, 0);
		$display("mode tests done");
		res_sel <= SAPM_RES12;
		push(bufw[0]);
		push(bufw[1]);
		@(posedge clk);
		chk(16'(smp_ready), 16'h0000);
		// drains in order; an empty buffer yields a zero result
		for (int k = 0; k < 3; k++) begin
			go(16, 1'b1, 0, 1);
			chk(HOST.word_q, {4'h0, bufw[k]});
		end
		$display("buffer test done");
		complete_run();
	end
endmodule // tb_serial_adc_frame_power_mode
